// file: hdl/fsp_pkg.sv
package fsp_pkg;
    // apb register byte offsets
    localparam logic [7:0] FSP_MC3_OFS = 8'h00;
    localparam logic [7:0] FSP_MC4_OFS = 8'h04;
    localparam logic [7:0] FSP_EIC_OFS = 8'h08;
    localparam logic [7:0] FSP_STAT_OFS = 8'h0C;
    localparam logic [7:0] FSP_ECNT_OFS = 8'h10;
    // master_config_three field positions
    localparam int FSP_MC3_OVD_INV = 0;
    localparam int FSP_MC3_OVE_INV = 1;
    localparam int FSP_MC3_TXCLK_INV = 2;
    // master_config_four field positions
    localparam int FSP_MC4_RX_OUTPUT_CLOCK_INV = 0;
    localparam int FSP_MC4_RX_DATA_OUT_INV = 1;
    localparam int FSP_MC4_RX_DATA_OUT_FORCE = 2;
    localparam int FSP_MC4_FORCE_LVL = 3;
    localparam int FSP_MC4_DIAG_LB = 4;
    // error_insert_control field positions
    localparam int FSP_EIC_MODE_SEL = 0;
    localparam int FSP_EIC_TYPE_LSB = 1;
    localparam int FSP_EIC_TYPE_W = 3;
    // reset values
    localparam logic [3:0] FSP_MC3_RST = 4'h0;
    localparam logic [4:0] FSP_MC4_RST = 5'h00;
    localparam logic [3:0] FSP_EIC_RST = 4'h0;
    localparam logic [15:0] FSP_ECNT_RST = 16'h0000;
    // error types
    localparam logic [2:0] FSP_ERR_FRAMING = 3'h0;
    localparam logic [2:0] FSP_ERR_PARITY = 3'h1;
    localparam logic [2:0] FSP_ERR_CODING = 3'h2;
    // edge detector state
    typedef enum logic [1:0] {
        FSP_LOW = 2'b00,
        FSP_RISE = 2'b01,
        FSP_HIGH = 2'b11,
        FSP_FALL = 2'b10
    } fsp_edge_t;
endpackage

// file: hdl/fsp_port.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - overwrite enable selects overwrite data bit
// - any bit position may be overwritten
// - overwrite data invert bit inverts data
// - manual strobe honoured only in manual mode
// - strobe rising edge inserts one typed error
// - one strobe shared, per-framer control used
// - common select picks common or own clock
// - tx clock invert inverts the selected clock, common or own
// - receive output clock follows line clock
// - diagnostic loopback sources clock from tx
// - invert bit picks rising or falling update
// - receive data invert bit inverts data
// - force bit holds receive output constant
// - one received bit out per clock cycle
// - overwrite enable invert makes it active low
module fsp_port
    import fsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_input_clock,
    input wire logic common_tx_clock,
    input wire logic common_clock_select,
    input wire logic tx_payload_in,
    input wire logic overwrite_data_in,
    input wire logic overwrite_enable_in,
    input wire logic manual_error_strobe,
    input wire logic rx_line_clock,
    input wire logic rx_line_data,
    output logic tx_data_out,
    output logic tx_error_pulse,
    output logic [2:0] tx_error_type,
    output logic rx_output_clock,
    output logic rx_data_out
);
    // two-flop synchronisers for every pin from outside sys_clk
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] sync1_q, sync2_q;
    wire logic [NSYNC-1:0] pins_in = {rx_line_data, rx_line_clock, manual_error_strobe, overwrite_enable_in,
                                      overwrite_data_in, tx_payload_in, common_clock_select,
                                      common_tx_clock, tx_input_clock};
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
        end
    end
    wire logic s_tx_input_clock = sync2_q[0];
    wire logic s_common_tx_clock = sync2_q[1];
    wire logic s_csel = sync2_q[2];
    wire logic s_payload = sync2_q[3];
    wire logic s_ovd = sync2_q[4];
    wire logic s_ove = sync2_q[5];
    wire logic s_strobe = sync2_q[6];
    wire logic s_rclk = sync2_q[7];
    wire logic s_rx_data_out = sync2_q[8];

    // registers
    logic [3:0] mc3_q;
    logic [4:0] mc4_q;
    logic [3:0] eic_q;
    logic [15:0] ecnt_q, ecnt_d;
    logic [31:0] prdata_q;
    logic pslverr_q, pready_q;

    // apb decode
    wire logic apb_setup = psel && !penable;
    wire logic hit_mc3 = paddr == FSP_MC3_OFS;
    wire logic hit_mc4 = paddr == FSP_MC4_OFS;
    wire logic hit_eic = paddr == FSP_EIC_OFS;
    wire logic hit_stat = paddr == FSP_STAT_OFS;
    wire logic hit_ecnt = paddr == FSP_ECNT_OFS;
    wire logic hit_any = hit_mc3 | hit_mc4 | hit_eic | hit_stat | hit_ecnt;
    // writes land in the access phase edge, answered with zero wait
    wire logic wr_en = psel && penable && pwrite && hit_any;

    // state visible to software
    logic tx_data_q, rx_data_q, rx_clk_q;
    wire logic [31:0] stat_word = {27'h0000000, s_csel, sync2_q[6], rx_clk_q, rx_data_q, tx_data_q};
    wire logic [31:0] rd_mux = hit_mc3 ? {28'h0000000, mc3_q} :
                               hit_mc4 ? {27'h0000000, mc4_q} :
                               hit_eic ? {28'h0000000, eic_q} :
                               hit_stat ? stat_word :
                               hit_ecnt ? {16'h0000, ecnt_q} : 32'h00000000;

    // apb answer: ready one cycle after setup so every access takes exactly two cycles
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup && !hit_any;
            prdata_q <= (apb_setup && !pwrite) ? rd_mux : 32'h00000000;
        end
    end
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // config register writes; status and counter are read only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mc3_q <= FSP_MC3_RST;
            mc4_q <= FSP_MC4_RST;
            eic_q <= FSP_EIC_RST;
        end else if (wr_en) begin
            if (hit_mc3) mc3_q <= pwdata[3:0];
            if (hit_mc4) mc4_q <= pwdata[4:0];
            if (hit_eic) eic_q <= pwdata[3:0];
        end
    end

    // edge detector, reused for every sampled clock and strobe
    function automatic fsp_edge_t edge_of(input logic prev, input logic cur);
        edge_of = fsp_edge_t'({prev, cur} == 2'b01 ? FSP_RISE :
                              {prev, cur} == 2'b10 ? FSP_FALL :
                              cur ? FSP_HIGH : FSP_LOW);
    endfunction

    // transmit clock: common clock when selected, optionally inverted per framer
    wire logic tx_clk_inv = mc3_q[FSP_MC3_TXCLK_INV];
    wire logic tx_clk_lvl = s_csel ? (s_common_tx_clock ^ tx_clk_inv) : (s_tx_input_clock ^ tx_clk_inv);
    logic tx_clk_prev_q;
    wire fsp_edge_t tx_edge = edge_of(tx_clk_prev_q, tx_clk_lvl);
    wire logic tx_tick = tx_edge == FSP_RISE;

    // overwrite port: polarity per config, any position may be replaced
    wire logic ov_active = s_ove ^ mc3_q[FSP_MC3_OVE_INV];
    wire logic ov_bit = s_ovd ^ mc3_q[FSP_MC3_OVD_INV];
    // no internal overhead generator here, so payload stands for the non-overwritten bit
    wire logic tx_next = ov_active ? ov_bit : s_payload;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_clk_prev_q <= 1'b0;
            tx_data_q <= 1'b0;
        end else begin
            tx_clk_prev_q <= tx_clk_lvl;
            if (tx_tick) tx_data_q <= tx_next;
        end
    end
    assign tx_data_out = tx_data_q;

    // manual error strobe: shared pin, this framer's own mode bit gates it
    logic strobe_prev_q, err_pulse_q;
    logic [2:0] err_type_q;
    wire fsp_edge_t strobe_edge = edge_of(strobe_prev_q, s_strobe);
    wire logic manual_mode = eic_q[FSP_EIC_MODE_SEL];
    wire logic err_fire = manual_mode && strobe_edge == FSP_RISE;
    assign ecnt_d = (ecnt_q == 16'hFFFF) ? ecnt_q : ecnt_q + 16'h0001;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            strobe_prev_q <= 1'b0;
            err_pulse_q <= 1'b0;
            err_type_q <= FSP_ERR_FRAMING;
            ecnt_q <= FSP_ECNT_RST;
        end else begin
            strobe_prev_q <= s_strobe;
            err_pulse_q <= err_fire;
            if (err_fire) begin
                err_type_q <= eic_q[FSP_EIC_TYPE_LSB +: FSP_EIC_TYPE_W];
                ecnt_q <= ecnt_d;
            end
        end
    end
    assign tx_error_pulse = err_pulse_q;
    assign tx_error_type = err_type_q;

    // receive clock source: line clock normally, tx clock in diagnostic loopback
    wire logic rx_src = mc4_q[FSP_MC4_DIAG_LB] ? s_tx_input_clock : s_rclk;
    wire logic rclk_inv = mc4_q[FSP_MC4_RX_OUTPUT_CLOCK_INV];
    wire logic rx_clk_lvl = rx_src ^ rclk_inv;
    logic rx_src_prev_q;
    wire fsp_edge_t rx_edge = edge_of(rx_src_prev_q, rx_src);
    // update on the source rising edge, which is a falling output edge when inverted
    wire logic rx_tick = rx_edge == FSP_RISE;
    wire logic rx_inv = s_rx_data_out ^ mc4_q[FSP_MC4_RX_DATA_OUT_INV];
    // forcing level chosen by a separate bit since one bit cannot name both levels
    wire logic rx_next = mc4_q[FSP_MC4_RX_DATA_OUT_FORCE] ? mc4_q[FSP_MC4_FORCE_LVL] : rx_inv;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_src_prev_q <= 1'b0;
            rx_clk_q <= 1'b0;
            rx_data_q <= 1'b0;
        end else begin
            rx_src_prev_q <= rx_src;
            rx_clk_q <= rx_clk_lvl;
            if (rx_tick) rx_data_q <= rx_next;
        end
    end
    assign rx_output_clock = rx_clk_q;
    assign rx_data_out = rx_data_q;
endmodule
`default_nettype wire

// file: sim/fsp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic manual_error_strobe,
    input wire logic tx_error_pulse,
    input wire logic common_clock_select,
    input wire logic common_tx_clock,
    input wire logic tx_input_clock,
    input wire logic tx_data_out,
    input wire logic rx_line_clock,
    input wire logic rx_output_clock,
    input wire logic rx_data_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // zero-wait slave: every setup is answered in the next cycle
    ready_in_access_a: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no ready in access cycle");
    error_with_ready_a: assert property (pslverr |-> pready) else $error("slave error without ready");
    idle_rdata_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    // one pulse per strobe edge, none long after the strobe went low
    single_error_a: assert property (tx_error_pulse |=> !tx_error_pulse) else $error("error pulse too long");
    no_strobe_a: assert property (!manual_error_strobe [*6] |=> !tx_error_pulse)
        else $error("error pulse without strobe");
    // with no clock edge and no register write the serial outputs must hold
    tx_hold_a: assert property (($stable(common_tx_clock) && $stable(tx_input_clock) &&
        $stable(common_clock_select) && !psel) [*8] |=> $stable(tx_data_out)) else $error("tx bit moved");
    rx_clk_hold_a: assert property (($stable(rx_line_clock) && $stable(tx_input_clock) && !psel) [*8]
        |=> $stable(rx_output_clock)) else $error("rx clock moved");
    rx_data_hold_a: assert property (($stable(rx_line_clock) && $stable(tx_input_clock) && !psel) [*8]
        |=> $stable(rx_data_out)) else $error("rx bit moved");
endmodule
`default_nettype wire

// file: sim/fsp_partner.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_partner (
    input wire logic run,
    input wire logic [1:0] bits,
    output logic tx_input_clock,
    output logic common_tx_clock,
    output logic rx_line_clock,
    output logic tx_payload_in,
    output logic rx_line_data
);
    // link clock toggles only within a burst; its edges fall on sys_clk falling edges
    initial begin
        tx_input_clock = 1'h0;
        tx_payload_in = 1'h0;
        rx_line_data = 1'h0;
    end
    always #100 if (run) tx_input_clock = !tx_input_clock;
    // opposite phase so the chosen source shows at the outputs
    assign common_tx_clock = !tx_input_clock;
    assign rx_line_clock = !tx_input_clock;
    // data moves half a period away from each sampling edge
    always @(negedge tx_input_clock) tx_payload_in <= bits[0];
    always @(posedge tx_input_clock) rx_line_data <= bits[1];
endmodule
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
    import fsp_pkg::*;
    logic sys_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, run = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic overwrite_data_in = 1'h0, overwrite_enable_in = 1'h0, common_clock_select = 1'h0;
    logic manual_error_strobe = 1'h0, pready, pslverr, er, tx_input_clock, common_tx_clock;
    logic tx_payload_in, rx_line_clock, rx_line_data, tx_data_out, tx_error_pulse, rx_output_clock, rx_data_out;
    logic [2:0] tx_error_type;
    logic [1:0] bits = 2'h0;
    logic [3:0] eicv [4] = '{4'h0, 4'h1, 4'h3, 4'h5};
    int errors = 0, cmp_count = 0, cyc = 0, pulses = 0;
    fsp_port i_dut (.*);
    fsp_partner i_far (.*);
    always #12.5 sys_clk = !sys_clk;
    // pulse counter and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (tx_error_pulse === 1'h1) pulses++;
        if (cyc == 30000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // idle edge first so psel is never assigned twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // burst of n link periods, then let the synchronisers settle
    task automatic link(input int n);
        @(posedge sys_clk) run <= 1'h1;
        repeat (8 * n) @(posedge sys_clk);
        run <= 1'h0;
        repeat (12) @(posedge sys_clk);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            if (i != 3) apb(1'h0, 8'(4 * i), 32'h0);
            if (i != 3) `CHK("reset value", 32'h0, rd)
        end
        apb(1'h1, FSP_ECNT_OFS, 32'hFFFF);
        apb(1'h0, FSP_ECNT_OFS, 32'h0);
        `CHK("read only count", 32'h0, rd)
        apb(1'h0, 8'h14, 32'h0);
        `CHK("unmapped error", 1'h1, er)
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            apb(1'h1, FSP_MC3_OFS, {29'h0, i[0], i[1:0]});
            overwrite_enable_in <= i[2];
            overwrite_data_in <= i[3];
            bits <= {1'h0, !i[3]};
            common_clock_select <= i[0];
            link(2);
            `CHK("tx bit", (i[2] ^ i[1]) ? (i[3] ^ i[0]) : !i[3], tx_data_out)
        end
        $display("test overwrite done");
        for (int i = 0; i < 32; i++) begin
            apb(1'h1, FSP_MC4_OFS, {27'h0, i[4:0]});
            bits <= {i[3] ^ i[0], 1'h0};
            link(2);
            `CHK("rx clock", (i[4] ? tx_input_clock : rx_line_clock) ^ i[0], rx_output_clock)
            if (!i[4]) `CHK("rx bit", i[2] ? i[3] : (i[3] ^ i[0] ^ i[1]), rx_data_out)
        end
        $display("test receive done");
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, FSP_EIC_OFS, {28'h0, eicv[i]});
            pulses = 0;
            manual_error_strobe <= 1'h1;
            repeat (8) @(posedge sys_clk);
            manual_error_strobe <= 1'h0;
            repeat (8) @(posedge sys_clk);
            `CHK("pulses", int'(eicv[i][0]), pulses)
            if (eicv[i][0]) `CHK("error type", eicv[i][3:1], tx_error_type)
        end
        apb(1'h0, FSP_ECNT_OFS, 32'h0);
        `CHK("error count", 32'h3, rd)
        apb(1'h0, FSP_STAT_OFS, 32'h0);
        `CHK("status", {27'h0, 1'h1, 1'h0, rx_output_clock, rx_data_out, tx_data_out}, rd)
        $display("test strobe done");
        give_verdict();
    end
endmodule
bind fsp_port fsp_chk u_chk (.*);
`default_nettype wire
